// ==== rtdp_pkg.sv ====
`default_nettype none
package rtdp_pkg;

    // channel and unit counts
    localparam int NCH = 11;
    localparam int NGRP = 4;
    localparam int NUNIT = NCH + NGRP;
    localparam int NVOTE_IN = 12;
    localparam int NVOTE = 2;
    localparam int TW = 16;
    localparam int DLYW = 16;
    localparam int TOW = 24;
    localparam int VCW = 4;

    // dropout ratio 0.99 as a fraction
    localparam int DROP_NUM = 99;
    localparam int DROP_DEN = 100;

    // group membership over channels 0..10
    localparam logic [NCH-1:0] GRP_W1_MASK = 11'h007;
    localparam logic [NCH-1:0] GRP_W2_MASK = 11'h038;
    localparam logic [NCH-1:0] GRP_AMB_MASK = 11'h0C0;
    localparam logic [NCH-1:0] GRP_AUX_MASK = 11'h700;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CHAN_EN = 8'h04;
    localparam logic [7:0] OFS_ALM_EN = 8'h08;
    localparam logic [7:0] OFS_ALM_DLY = 8'h0C;
    localparam logic [7:0] OFS_TIMEOUT = 8'h10;
    localparam logic [7:0] OFS_VOTE1 = 8'h14;
    localparam logic [7:0] OFS_VOTE2 = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_UNIT_TRIP = 8'h20;
    localparam logic [7:0] OFS_UNIT_ALM = 8'h24;
    localparam logic [7:0] OFS_CH_TMO = 8'h28;
    localparam logic [7:0] OFS_THR_BASE = 8'h40;

    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SEL_BIT = 1;
    localparam int VOTE_CNT_LSB = 16;
    localparam int VOTE_ACT_BIT = 31;
    localparam int THR_ALM_LSB = 16;

    // reset values
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_CHAN_EN = 32'h0000_07FF;
    localparam logic [31:0] RST_ALM_EN = 32'h0000_0000;
    localparam logic [31:0] RST_ALM_DLY = 32'h0000_0100;
    localparam logic [31:0] RST_VOTE = 32'h0000_0000;
    localparam logic [31:0] RST_THR = 32'hFFFF_FFFF;

    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int TIMEOUT_MS = 100;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [NCH-1:0] upd;
        logic [NCH*TW-1:0] temp;
    } rtdp_sensor_t;

    typedef struct packed {
        logic trip_cmd;
        logic trip_any;
        logic alarm_any;
        logic timeout_any;
        logic coll_timeout;
        logic [NVOTE-1:0] vote_trip;
    } rtdp_stat_t;

endpackage
`default_nettype wire

// ==== rtdp_top.sv ====
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module rtdp_top #(
    parameter int TIMEOUT_CYC = rtdp_pkg::TIMEOUT_CYC
) (
    input wire logic aclk,                       // 50 MHz clock
    input wire logic aresetn,                    // sync reset, low
    input wire rtdp_pkg::rtdp_sensor_t sensor,   // temps and update pulses
    input wire logic trip_block,                 // async trip block pin
    input wire logic [7:0] s_awaddr,             // axi write address
    input wire logic s_awvalid,                  // axi
    output logic s_awready,                      // axi
    input wire logic [31:0] s_wdata,             // axi write data
    input wire logic [3:0] s_wstrb,              // axi byte strobes
    input wire logic s_wvalid,                   // axi
    output logic s_wready,                       // axi
    output logic [1:0] s_bresp,                  // axi
    output logic s_bvalid,                       // axi
    input wire logic s_bready,                   // axi
    input wire logic [7:0] s_araddr,             // axi read address
    input wire logic s_arvalid,                  // axi
    output logic s_arready,                      // axi
    output logic [31:0] s_rdata,                 // axi read data
    output logic [1:0] s_rresp,                  // axi
    output logic s_rvalid,                       // axi
    input wire logic s_rready,                   // axi
    output rtdp_pkg::rtdp_stat_t status,         // collective outputs
    output logic [rtdp_pkg::NUNIT-1:0] unit_trip,  // per unit trips
    output logic [rtdp_pkg::NUNIT-1:0] unit_alarm  // per unit alarms
);

    localparam int NCH = rtdp_pkg::NCH;
    localparam int NU = rtdp_pkg::NUNIT;
    localparam int TW = rtdp_pkg::TW;

    if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 2**rtdp_pkg::TOW - 1) begin : g_chk
        $error("TIMEOUT_CYC out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic aw_hold_ff, w_hold_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic wr_fire;
    logic [31:0] ctrl_ff, chan_en_ff, alm_en_ff, alm_dly_ff, tmo_ff;
    logic [31:0] vote_ff [rtdp_pkg::NVOTE];
    logic [31:0] thr_ff [NU];

    assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && ((a <= rtdp_pkg::OFS_CH_TMO) ||
            ((a >= rtdp_pkg::OFS_THR_BASE) &&
             (a < rtdp_pkg::OFS_THR_BASE + 8'(4 * NU))));
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= rtdp_pkg::RESP_OKAY;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_awvalid && awready_ff) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_awaddr;
                awready_ff <= 1'b0;
            end else if (!aw_hold_ff && !bvalid_ff) begin
                awready_ff <= 1'b1;
            end
            if (s_wvalid && wready_ff) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= s_wdata;
                wstrb_ff <= s_wstrb;
                wready_ff <= 1'b0;
            end else if (!w_hold_ff && !bvalid_ff) begin
                wready_ff <= 1'b1;
            end
            if (wr_fire) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                // status words are read-only, writing them is an error
                bresp_ff <= (mapped(awaddr_ff) &&
                    (awaddr_ff < rtdp_pkg::OFS_STATUS ||
                     awaddr_ff >= rtdp_pkg::OFS_THR_BASE)) ?
                    rtdp_pkg::RESP_OKAY : rtdp_pkg::RESP_SLVERR;
            end else if (bvalid_ff && s_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= rtdp_pkg::RST_CTRL;
            chan_en_ff <= rtdp_pkg::RST_CHAN_EN;
            alm_en_ff <= rtdp_pkg::RST_ALM_EN;
            alm_dly_ff <= rtdp_pkg::RST_ALM_DLY;
            tmo_ff <= 32'(TIMEOUT_CYC);
            for (int v = 0; v < rtdp_pkg::NVOTE; v++) begin
                vote_ff[v] <= rtdp_pkg::RST_VOTE;
            end
            for (int u = 0; u < NU; u++) begin
                thr_ff[u] <= rtdp_pkg::RST_THR;
            end
        end else if (wr_fire) begin
            case (awaddr_ff)
                rtdp_pkg::OFS_CTRL:
                    ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff) & 32'h3;
                rtdp_pkg::OFS_CHAN_EN:
                    chan_en_ff <= merge(chan_en_ff, wdata_ff, wstrb_ff)
                        & 32'h0000_07FF;
                rtdp_pkg::OFS_ALM_EN:
                    alm_en_ff <= merge(alm_en_ff, wdata_ff, wstrb_ff)
                        & 32'h0000_7FFF;
                rtdp_pkg::OFS_ALM_DLY:
                    alm_dly_ff <= merge(alm_dly_ff, wdata_ff, wstrb_ff)
                        & 32'h0000_FFFF;
                rtdp_pkg::OFS_TIMEOUT:
                    tmo_ff <= merge(tmo_ff, wdata_ff, wstrb_ff)
                        & 32'h00FF_FFFF;
                rtdp_pkg::OFS_VOTE1:
                    vote_ff[0] <= merge(vote_ff[0], wdata_ff, wstrb_ff)
                        & 32'h800F_0FFF;
                rtdp_pkg::OFS_VOTE2:
                    vote_ff[1] <= merge(vote_ff[1], wdata_ff, wstrb_ff)
                        & 32'h800F_0FFF;
                default: begin
                    for (int u = 0; u < NU; u++) begin
                        if (awaddr_ff == rtdp_pkg::OFS_THR_BASE + 8'(4 * u)) begin
                            thr_ff[u] <= merge(thr_ff[u], wdata_ff, wstrb_ff);
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sensor evaluation

    logic blk_s1_ff, blk_s2_ff;
    logic [NU-1:0] trip_ff, alarm_ff, on_w, to_w;
    logic [NCH-1:0] ch_tmo_ff;
    logic [rtdp_pkg::TOW-1:0] age_ff [NCH];
    logic [TW-1:0] val_w [NU];
    logic [rtdp_pkg::DLYW-1:0] cnt_ff [NU];
    logic glob_en;
    logic [rtdp_pkg::NGRP*NCH-1:0] grp_masks;

    assign glob_en = ctrl_ff[rtdp_pkg::CTRL_EN_BIT];
    assign grp_masks = {rtdp_pkg::GRP_AUX_MASK, rtdp_pkg::GRP_AMB_MASK,
                        rtdp_pkg::GRP_W2_MASK, rtdp_pkg::GRP_W1_MASK};

    // pin crosses two flops before anything looks at it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blk_s1_ff <= 1'b0;
            blk_s2_ff <= 1'b0;
        end else begin
            blk_s1_ff <= trip_block;
            blk_s2_ff <= blk_s1_ff;
        end
    end

    function automatic logic [TW-1:0] hottest(input logic [NCH*TW-1:0] t,
                                              input logic [NCH-1:0] m);
        logic [TW-1:0] h;
        h = '0;
        for (int c = 0; c < NCH; c++) begin
            if (m[c] && t[c*TW +: TW] > h) begin
                h = t[c*TW +: TW];
            end
        end
        return h;
    endfunction

    // 32-bit products keep the 0.99 compare exact
    function automatic logic below_drop(input logic [TW-1:0] v,
                                        input logic [TW-1:0] thr);
        return (32'(v) * 32'(rtdp_pkg::DROP_DEN)) <
               (32'(thr) * 32'(rtdp_pkg::DROP_NUM));
    endfunction

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                age_ff[c] <= '0;
                ch_tmo_ff[c] <= 1'b0;
            end else if (sensor.upd[c]) begin
                age_ff[c] <= '0;
                ch_tmo_ff[c] <= 1'b0;
            end else begin
                if (age_ff[c] < tmo_ff[rtdp_pkg::TOW-1:0]) begin
                    age_ff[c] <= age_ff[c] + 1'b1;
                end
                ch_tmo_ff[c] <= glob_en && chan_en_ff[c] &&
                    (age_ff[c] >= tmo_ff[rtdp_pkg::TOW-1:0]);
            end
        end
    end

    for (genvar u = 0; u < NU; u++) begin : g_unit
        logic [TW-1:0] trip_thr, alm_thr;
        logic t_drop, a_drop;
        assign trip_thr = thr_ff[u][TW-1:0];
        assign alm_thr = thr_ff[u][rtdp_pkg::THR_ALM_LSB +: TW];
        if (u < NCH) begin : g_single
            assign val_w[u] = sensor.temp[u*TW +: TW];
            assign on_w[u] = glob_en && chan_en_ff[u];
            assign to_w[u] = ch_tmo_ff[u];
        end else begin : g_group
            // hottest enabled member stands for the group
            localparam int G = u - NCH;
            logic [NCH-1:0] m;
            assign m = grp_masks[G*NCH +: NCH];
            assign val_w[u] = hottest(sensor.temp, m & chan_en_ff[NCH-1:0]);
            assign on_w[u] = glob_en && |(m & chan_en_ff[NCH-1:0]);
            assign to_w[u] = |(m & ch_tmo_ff);
        end
        assign t_drop = below_drop(val_w[u], trip_thr);
        assign a_drop = below_drop(val_w[u], alm_thr);

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                trip_ff[u] <= 1'b0;
            end else if (!on_w[u] || blk_s2_ff) begin
                trip_ff[u] <= 1'b0;
            end else if (trip_ff[u]) begin
                trip_ff[u] <= !t_drop;
            end else begin
                trip_ff[u] <= val_w[u] > trip_thr;
            end
        end

        // delay restarts on dropout rather than counting down
        always_ff @(posedge aclk) begin
            if (!aresetn || !on_w[u] || !alm_en_ff[u]) begin
                alarm_ff[u] <= 1'b0;
                cnt_ff[u] <= '0;
            end else if (alarm_ff[u]) begin
                if (a_drop) begin
                    alarm_ff[u] <= 1'b0;
                    cnt_ff[u] <= '0;
                end
            end else if (a_drop) begin
                cnt_ff[u] <= '0;
            end else if (val_w[u] > alm_thr || cnt_ff[u] != '0) begin
                if (cnt_ff[u] >= alm_dly_ff[rtdp_pkg::DLYW-1:0]) begin
                    alarm_ff[u] <= 1'b1;
                end else begin
                    cnt_ff[u] <= cnt_ff[u] + 1'b1;
                end
            end
        end

        a_trip_hyst: assert property (@(posedge aclk) disable iff (!aresetn)
            trip_ff[u] && on_w[u] && !blk_s2_ff && !t_drop |=> trip_ff[u])
            else $error("trip dropped above dropout level");
        a_alarm_delay: assert property (@(posedge aclk) disable iff (!aresetn)
            $rose(alarm_ff[u]) |->
                $past(cnt_ff[u]) >= $past(alm_dly_ff[rtdp_pkg::DLYW-1:0]))
            else $error("alarm raised before delay elapsed");
    end

    ////////////////////////////////////////////////////////////////////////
    // voting and collective outputs

    logic [rtdp_pkg::NVOTE_IN-1:0] vote_in;
    logic [rtdp_pkg::NVOTE-1:0] vote_w;
    logic [rtdp_pkg::NGRP-1:0] grp_trip, grp_alm, grp_to;
    rtdp_pkg::rtdp_stat_t stat_ff;

    assign grp_trip = trip_ff[NU-1:NCH];
    assign grp_alm = alarm_ff[NU-1:NCH];
    assign grp_to = to_w[NU-1:NCH];
    // eleven channel trips plus the auxiliary group trip
    assign vote_in = {grp_trip[rtdp_pkg::NGRP-1], trip_ff[NCH-1:0]};

    function automatic logic [rtdp_pkg::VCW-1:0] ones(
        input logic [rtdp_pkg::NVOTE_IN-1:0] x);
        logic [rtdp_pkg::VCW-1:0] n;
        n = '0;
        for (int i = 0; i < rtdp_pkg::NVOTE_IN; i++) begin
            n = n + rtdp_pkg::VCW'(x[i]);
        end
        return n;
    endfunction

    for (genvar v = 0; v < rtdp_pkg::NVOTE; v++) begin : g_vote
        logic [rtdp_pkg::VCW-1:0] need;
        assign need = vote_ff[v][rtdp_pkg::VOTE_CNT_LSB +: rtdp_pkg::VCW];
        assign vote_w[v] = vote_ff[v][rtdp_pkg::VOTE_ACT_BIT] &&
            need != '0 && !blk_s2_ff &&
            ones(vote_in & vote_ff[v][rtdp_pkg::NVOTE_IN-1:0]) >= need;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_ff <= '0;
        end else begin
            stat_ff.trip_any <= |grp_trip;
            stat_ff.alarm_any <= |grp_alm;
            stat_ff.timeout_any <= |grp_to;
            stat_ff.coll_timeout <= |ch_tmo_ff || |grp_to;
            stat_ff.vote_trip <= vote_w;
            stat_ff.trip_cmd <= !blk_s2_ff &&
                (ctrl_ff[rtdp_pkg::CTRL_SEL_BIT] ? |vote_w
                                                 : |trip_ff);
        end
    end

    assign status = stat_ff;
    assign unit_trip = trip_ff;
    assign unit_alarm = alarm_ff;

    a_block_trip: assert property (@(posedge aclk) disable iff (!aresetn)
        blk_s2_ff |=> !stat_ff.trip_cmd && stat_ff.vote_trip == '0)
        else $error("trip issued while blocked");
    a_source_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_ff[rtdp_pkg::CTRL_SEL_BIT] && !blk_s2_ff |=>
            stat_ff.trip_cmd == $past(|trip_ff))
        else $error("default trip path mismatch");
    a_vote_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !vote_ff[0][rtdp_pkg::VOTE_ACT_BIT] |=> !stat_ff.vote_trip[0])
        else $error("inactive vote tripped");
    a_global_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !glob_en |=> trip_ff == '0 ##1 stat_ff.trip_any == 1'b0)
        else $error("trip with protection disabled");
    a_any_alarm: assert property (@(posedge aclk) disable iff (!aresetn)
        |grp_alm |=> stat_ff.alarm_any)
        else $error("group alarm not collected");
    a_coll_tmo: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 stat_ff.coll_timeout == $past(|ch_tmo_ff || |grp_to))
        else $error("collective timeout mismatch");
    a_b_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped early");

    ////////////////////////////////////////////////////////////////////////
    // read path

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            rtdp_pkg::OFS_CTRL: r = ctrl_ff;
            rtdp_pkg::OFS_CHAN_EN: r = chan_en_ff;
            rtdp_pkg::OFS_ALM_EN: r = alm_en_ff;
            rtdp_pkg::OFS_ALM_DLY: r = alm_dly_ff;
            rtdp_pkg::OFS_TIMEOUT: r = tmo_ff;
            rtdp_pkg::OFS_VOTE1: r = vote_ff[0];
            rtdp_pkg::OFS_VOTE2: r = vote_ff[1];
            rtdp_pkg::OFS_STATUS: r = {25'h0, stat_ff};
            rtdp_pkg::OFS_UNIT_TRIP: r = {17'h0, trip_ff};
            rtdp_pkg::OFS_UNIT_ALM: r = {17'h0, alarm_ff};
            rtdp_pkg::OFS_CH_TMO: r = {21'h0, ch_tmo_ff};
            default: begin
                for (int u = 0; u < NU; u++) begin
                    if (a == rtdp_pkg::OFS_THR_BASE + 8'(4 * u)) begin
                        r = thr_ff[u];
                    end
                end
            end
        endcase
        return r;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= rtdp_pkg::RESP_OKAY;
        end else if (s_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux(s_araddr);
            rresp_ff <= mapped(s_araddr) ? rtdp_pkg::RESP_OKAY
                                         : rtdp_pkg::RESP_SLVERR;
        end else if (rvalid_ff && s_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end else if (!rvalid_ff) begin
            arready_ff <= 1'b1;
        end
    end

    assign s_awready = awready_ff;
    assign s_wready = wready_ff;
    assign s_bvalid = bvalid_ff;
    assign s_bresp = bresp_ff;
    assign s_arready = arready_ff;
    assign s_rvalid = rvalid_ff;
    assign s_rdata = rdata_ff;
    assign s_rresp = rresp_ff;

endmodule

`default_nettype wire

// ==== rtdp_sensor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtdp_sensor_model (
    input wire logic aclk, // clock
    input wire logic [rtdp_pkg::NCH*rtdp_pkg::TW-1:0] temp_in, // temps
    input wire logic [rtdp_pkg::NCH-1:0] mute, // silent channels
    output var rtdp_pkg::rtdp_sensor_t sensor // toward the block
);
    logic [2:0] tick_ff = 3'h0;
    // fresh sample every 8 cycles, well inside the 20-cycle timeout
    always_ff @(posedge aclk) begin
        tick_ff <= tick_ff + 3'h1;
        sensor.upd <= (tick_ff == 3'h7) ? ~mute : '0;
        sensor.temp <= temp_in;
    end
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
logic aclk = 0, aresetn = 0, trip_block = 0;
logic [7:0] s_awaddr = 0, s_araddr = 0;
logic [31:0] s_wdata = 0, s_rdata, rd;
logic [3:0] s_wstrb = 4'hF;
logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
logic s_rready = 0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
logic [1:0] s_bresp, s_rresp, rsp;
logic [175:0] temp = 0;
logic [10:0] mute = 0;
rtdp_pkg::rtdp_sensor_t sensor;
rtdp_pkg::rtdp_stat_t status;
logic [14:0] unit_trip, unit_alarm;
int n_mismatch = 0, comparisons = 0, cyc = 0;
always #10 aclk = ~aclk;
rtdp_sensor_model u_rtdp_sensor_model(.aclk, .temp_in(temp), .mute,
    .sensor);
rtdp_top #(.TIMEOUT_CYC(20)) u_rtdp_top(.aclk, .aresetn, .sensor,
    .trip_block, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .status, .unit_trip, .unit_alarm);
////////////////////////////////////////////////////////////////////////
task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask
always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
        n_mismatch++;
        close_out;
    end
end
task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
endtask
task automatic wt(input int n);
    repeat (n) @(posedge aclk);
endtask
task automatic st(input int c, input logic [15:0] v);
    temp[c*16 +: 16] <= v;
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 0;
    s_awaddr <= a; s_wdata <= d; s_awvalid <= 1; s_wvalid <= 1;
    // bready only after bvalid shows, so the response is made to wait
    do begin
        @(posedge aclk);
        if (s_awready) s_awvalid <= 0;
        if (s_wready) s_wvalid <= 0;
        if (s_bvalid && s_bready) begin
            rsp = s_bresp; s_bready <= 0; done = 1;
        end else if (s_bvalid) begin
            s_bready <= 1;
        end
    end while (!done);
endtask
task automatic rdr(input logic [7:0] a);
    logic done;
    done = 0;
    s_araddr <= a; s_arvalid <= 1;
    do begin
        @(posedge aclk);
        if (s_arready) s_arvalid <= 0;
        if (s_rvalid && s_rready) begin
            rd = s_rdata; rsp = s_rresp; s_rready <= 0; done = 1;
        end else if (s_rvalid) begin
            s_rready <= 1;
        end
    end while (!done);
endtask
////////////////////////////////////////////////////////////////////////
task automatic t_reset;
    rdr(8'h04); chk("chan_en", rd, 32'h7FF);
    rdr(8'h0C); chk("alm_dly", rd, 32'h100);
    rdr(8'h3C); chk("unmapped", 32'(rsp), 32'h2);
    wr(8'h1C, 32'hFF); chk("ro write", 32'(rsp), 32'h2);
    chk("idle", 32'(status), 32'h0);
    $display("test reset done");
endtask
task automatic t_trip;
    wr(8'h40, 32'h03E8_03E8); wr(8'h6C, 32'h03E8_03E8);
    wr(8'h08, 32'h801); wr(8'h0C, 32'h4);
    st(0, 16'h03E9); wt(4);
    chk("off", 32'(unit_trip[0]), 32'h0);
    wr(8'h00, 32'h1); wt(2);
    chk("trip", {unit_trip[11], unit_trip[0], status.trip_any,
        status.trip_cmd}, 32'hF);
    chk("early", 32'(unit_alarm[0]), 32'h0);
    wt(8); chk("alarm", {unit_alarm[0], status.alarm_any}, 32'h3);
    st(0, 16'h03DE); wt(4); chk("hold", 32'(unit_trip[0]), 32'h1);
    st(0, 16'h03DD); wt(4);
    chk("drop", {unit_trip[0], unit_alarm[0]}, 32'h0);
    st(0, 16'h03E9); trip_block <= 1; wt(6);
    chk("block", {unit_trip[0], status.trip_cmd}, 32'h0);
    trip_block <= 0; st(0, 16'h0); wt(4);
    $display("test trip done");
endtask
task automatic t_vote;
    wr(8'h44, 32'h03E8_03E8); wr(8'h14, 32'h8002_0003); wr(8'h00, 32'h3);
    st(0, 16'h03E9); wt(4);
    chk("one", {status.vote_trip, status.trip_cmd}, 32'h0);
    st(1, 16'h03E9); wt(4);
    chk("two", {status.vote_trip, status.trip_cmd}, 32'h3);
    wr(8'h04, 32'h7FD); wt(4);
    chk("chan off", 32'(status.vote_trip), 32'h0);
    wr(8'h18, 32'h8001_0001); wt(4);
    chk("vote two", 32'(status.vote_trip), 32'h2);
    wr(8'h04, 32'h7FF); wr(8'h14, 32'h0002_0003);
    wr(8'h18, 32'h0001_0001); wt(4);
    chk("inactive", 32'(status.vote_trip), 32'h0);
    st(0, 16'h0); st(1, 16'h0); wr(8'h00, 32'h1); wt(4);
    $display("test vote done");
endtask
task automatic t_timeout;
    mute <= 11'h020; wt(30);
    chk("tmo", {status.timeout_any, status.coll_timeout}, 32'h3);
    rdr(8'h28); chk("tmo ch", rd, 32'h20);
    mute <= 11'h0; wt(12);
    chk("tmo clr", {status.timeout_any, status.coll_timeout}, 32'h0);
    $display("test timeout done");
endtask
task automatic t_rst2;
    st(0, 16'h03E9); wt(6);
    chk("pre rst", 32'(unit_trip[0]), 32'h1);
    aresetn <= 0; wt(2); aresetn <= 1; wt(2);
    chk("rst units", 32'({unit_trip, unit_alarm}), 32'h0);
    chk("rst stat", 32'(status), 32'h0);
    rdr(8'h40); chk("rst thr", rd, 32'hFFFF_FFFF);
    $display("test reset again done");
endtask
initial begin
    wt(8); aresetn <= 1; wt(2);
    t_reset; t_trip; t_vote; t_timeout; t_rst2;
    close_out;
end
endmodule
`default_nettype wire
